/* File: logic/sqwg_pkg.sv */
// Shared constants and types for the square-wave generator
package sqwg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_RELOAD = 16'h1FB8;
  localparam logic [15:0] IDX_COUNT = 16'h1FBA;
  localparam logic [15:0] IDX_PINCTL = 16'h1FBC;
  localparam logic [15:0] IDX_PINSTAT = 16'h1FBE;
  localparam int unsigned BYTE_SHIFT = 2;

  // Data widths
  localparam int unsigned CNT_W = 8;
  localparam int unsigned DAT_W = 32;

  // Reset values
  localparam logic [7:0] RST_RELOAD = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [2:0] RST_PINCTL = 3'h0;

  // Pin control field positions
  localparam int unsigned PC_SPECIAL = 0;
  localparam int unsigned PC_DIR = 1;
  localparam int unsigned PC_DATA = 2;
  localparam int unsigned PC_W = 3;

  // Timing: state times per count step, MCLK cycles per state time
  localparam int unsigned STATES_PER_STEP = 8;
  localparam int unsigned STEP_W = 3;
  localparam int unsigned DEF_STATE_DIV = 1;

  // Pin control register layout
  typedef struct packed {
    logic data;
    logic dir;
    logic special;
  } sqwg_pinctl_s;

  // One bus request as seen by the slave
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] idx;
    logic lane0;
    logic [DAT_W-1:0] wdat;
  } sqwg_req_s;

endpackage

/* File: logic/sqwg_top.sv */
// Square-wave frequency generator with Wishbone register slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module sqwg_top #(
  parameter int unsigned ADR_W = 16,
  parameter int unsigned STATE_DIV = sqwg_pkg::DEF_STATE_DIV
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Square-wave output pin, three-signal form
  input wire logic SQW_PIN_I,
  output logic SQW_PIN_O,
  output logic SQW_PIN_OE
);

  localparam int unsigned DIV_W = (STATE_DIV > 1) ? $clog2(STATE_DIV) : 1;

  // Elaboration checks
  if (STATE_DIV < 1) begin : g_bad_div
    $error("STATE_DIV must be at least 1");
  end
  if (ADR_W < 16 || ADR_W > 32) begin : g_bad_adr
    $error("ADR_W must lie between 16 and 32");
  end
  if ((1 << sqwg_pkg::STEP_W) != sqwg_pkg::STATES_PER_STEP) begin : g_bad_step
    $error("STEP_W must count exactly STATES_PER_STEP state times");
  end

  logic [DIV_W-1:0] div_cnt;
  logic state_tick;
  logic [sqwg_pkg::STEP_W-1:0] step_cnt;
  logic dec_tick;
  logic [sqwg_pkg::CNT_W-1:0] reload;
  logic [sqwg_pkg::CNT_W-1:0] count;
  logic wave;
  sqwg_pkg::sqwg_pinctl_s pinctl;
  sqwg_pkg::sqwg_req_s req;
  logic pin_meta;
  logic pin_sync;
  logic [sqwg_pkg::DAT_W-1:0] next_dat;
  logic wr_reload;
  logic wr_pinctl;

  // Request carrier; only the word index matters to the decode
  always_comb begin
    req.req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    req.we = WB_WE_I;
    // Index bits above sixteen are cut on purpose; the map never reaches them
    req.idx = 16'(WB_ADR_I[ADR_W-1:sqwg_pkg::BYTE_SHIFT]);
    req.lane0 = WB_SEL_I[0];
    req.wdat = WB_DAT_I;
  end

  assign wr_reload = req.req & req.we & req.lane0 & (req.idx == sqwg_pkg::IDX_RELOAD);
  assign wr_pinctl = req.req & req.we & req.lane0 & (req.idx == sqwg_pkg::IDX_PINCTL);

  // State-time enable from MCLK
  // STATE_DIV stretches one state time over several MCLK cycles; 1 gives one per cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= '0;
      state_tick <= 1'b0;
    end else if (div_cnt == DIV_W'(STATE_DIV - 1)) begin
      div_cnt <= '0;
      state_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      state_tick <= 1'b0;
    end
  end

  // One count step every eighth state time
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      step_cnt <= '0;
      dec_tick <= 1'b0;
    end else begin
      dec_tick <= 1'b0;
      if (state_tick) begin
        step_cnt <= step_cnt + 1'b1;
        dec_tick <= (step_cnt == sqwg_pkg::STEP_W'(sqwg_pkg::STATES_PER_STEP - 1));
      end
    end
  end

  // Reload value register, software written
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reload <= sqwg_pkg::RST_RELOAD;
    end else if (wr_reload) begin
      reload <= req.wdat[sqwg_pkg::CNT_W-1:0];
    end
  end

  // Down-counter and output toggle; a bus write never touches the count
  // A zero reload gives the fastest wave: one count step per half period
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= sqwg_pkg::RST_COUNT;
      wave <= 1'b0;
    end else if (dec_tick) begin
      if (count == '0) begin
        count <= reload;
        wave <= ~wave;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  // Pin control register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pinctl <= sqwg_pkg::RST_PINCTL;
    end else if (wr_pinctl) begin
      pinctl <= req.wdat[sqwg_pkg::PC_W-1:0];
    end
  end

  // Pin level synchroniser for readback
  // Only the second flop is read, so a metastable first stage never reaches the bus
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= SQW_PIN_I;
      pin_sync <= pin_meta;
    end
  end

  // Pin mux; registered, so the pin lags the wave by one MCLK cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SQW_PIN_O <= 1'b0;
      SQW_PIN_OE <= 1'b0;
    end else if (pinctl.special) begin
      SQW_PIN_O <= wave;
      SQW_PIN_OE <= 1'b1;
    end else begin
      SQW_PIN_O <= pinctl.data;
      SQW_PIN_OE <= pinctl.dir;
    end
  end

  // Read decode; unmapped addresses read as zero and are still acknowledged
  always_comb begin
    next_dat = '0;
    if (req.idx == sqwg_pkg::IDX_RELOAD) begin
      next_dat[sqwg_pkg::CNT_W-1:0] = reload;
    end else if (req.idx == sqwg_pkg::IDX_COUNT) begin
      next_dat[sqwg_pkg::CNT_W-1:0] = count;
    end else if (req.idx == sqwg_pkg::IDX_PINCTL) begin
      next_dat[sqwg_pkg::PC_W-1:0] = pinctl;
    end else if (req.idx == sqwg_pkg::IDX_PINSTAT) begin
      next_dat[0] = pin_sync;
      next_dat[1] = wave;
    end
  end

  // Bus answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= req.req;
      if (req.req && !req.we) begin
        WB_DAT_O <= next_dat;
      end
    end
  end

  // Checks
  sequence s_expire;
    dec_tick && (count == '0);
  endsequence

  sequence s_step;
    dec_tick && (count != '0);
  endsequence

  sequence s_rd(logic [15:0] want);
    req.req && !req.we && (req.idx == want);
  endsequence

  sequence s_wr(logic [15:0] want);
    req.req && req.we && req.lane0 && (req.idx == want);
  endsequence

  expire_reload_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_expire |=> (wave != $past(wave)) && (count == $past(reload)))
    else $error("Counter expiry did not toggle and reload");

  step_down_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_step |=> (count == $past(count) - 8'h01) && $stable(wave))
    else $error("Counter did not step down by one");

  tick_spacing_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (dec_tick && STATE_DIV == 1) |=> !dec_tick [*7] ##1 dec_tick)
    else $error("Count steps not eight state times apart");

  count_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rd(sqwg_pkg::IDX_COUNT) |=> WB_ACK_O && (WB_DAT_O[7:0] == $past(count)))
    else $error("Counter read returned wrong value");

  count_ro_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (req.req && req.we && req.idx == sqwg_pkg::IDX_COUNT && !dec_tick) |=> $stable(count))
    else $error("Write changed the down-counter");

  reload_rw_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_reload ##3 s_rd(sqwg_pkg::IDX_RELOAD) |=> WB_DAT_O[7:0] == $past(req.wdat[7:0], 4))
    else $error("Reload value not read back");

  wave_cause_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wave != $past(wave)) |-> $past(dec_tick && count == '0))
    else $error("Wave changed without expiry");

  pin_mux_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    pinctl.special |=> SQW_PIN_OE && (SQW_PIN_O == $past(wave)))
    else $error("Pin not carrying the wave in special mode");

  defer_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_reload && !dec_tick) |=> (count == $past(count)))
    else $error("Reload write disturbed the countdown");

  // Bus answer: one registered pulse per taken request, read data held between reads
  ack_follow_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    req.req |=> WB_ACK_O)
    else $error("Request not acknowledged");

  ack_pulse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("Acknowledge stood for more than one cycle");

  ack_idle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("Acknowledge without a request");

  dat_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(req.req && !req.we) |=> $stable(WB_DAT_O))
    else $error("Read data changed without a read");

  rd_upper_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    WB_ACK_O |-> (WB_DAT_O[31:8] == '0))
    else $error("Read data above the eight-bit field not zero");

  unmapped_rd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (req.req && !req.we && (req.idx != sqwg_pkg::IDX_RELOAD) && (req.idx != sqwg_pkg::IDX_COUNT)
      && (req.idx != sqwg_pkg::IDX_PINCTL) && (req.idx != sqwg_pkg::IDX_PINSTAT)) |=> (WB_DAT_O == '0))
    else $error("Unmapped read not zero");

  // Registers: writes land whole, and nothing else moves them
  reload_wr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_wr(sqwg_pkg::IDX_RELOAD) |=> (reload == $past(req.wdat[7:0])))
    else $error("Reload write did not land");

  reload_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !wr_reload |=> $stable(reload))
    else $error("Reload value moved without a write");

  lane_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (req.req && req.we && !req.lane0) |=> $stable(reload) && $stable(pinctl))
    else $error("Write with low byte lane off changed a register");

  pinctl_wr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_wr(sqwg_pkg::IDX_PINCTL) |=> (pinctl == $past(req.wdat[2:0])))
    else $error("Pin control write did not land");

  pinctl_rd_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rd(sqwg_pkg::IDX_PINCTL) |=> (WB_DAT_O[2:0] == $past(pinctl)))
    else $error("Pin control read returned wrong value");

  // Pin: plain port behaviour outside special mode, and the status readback
  pin_plain_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !pinctl.special |=> (SQW_PIN_OE == $past(pinctl.dir)) && (SQW_PIN_O == $past(pinctl.data)))
    else $error("Pin not acting as plain port");

  pin_stat_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_rd(sqwg_pkg::IDX_PINSTAT) |=> (WB_DAT_O[1:0] == {$past(wave), $past(pin_sync)}))
    else $error("Pin status read returned wrong value");

  // Count steps: phase of the step counter and a quiet count between steps
  step_phase_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    dec_tick |-> (step_cnt == '0))
    else $error("Count step out of phase with the state-time counter");

  count_idle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !dec_tick |=> $stable(count))
    else $error("Down-counter moved between count steps");

endmodule

`default_nettype wire

/* File: testbench/sqwg_load.sv */
// Load model on the square-wave pin: measures the half period
`timescale 1ns/1ps
`default_nettype none
module sqwg_load (
  // Clock and pin
  input wire logic MCLK,
  input wire logic PIN,
  // Last half period in cycles
  output int half
);
  int n = 0;
  logic last = 1'b1;
  initial half = 0;
  always @(posedge MCLK) begin
    n <= n + 1;
    if (PIN !== last) begin
      half <= n;
      n <= 1;
    end
    last <= PIN;
  end
endmodule
`default_nettype wire

/* File: testbench/square_wave_frequency_generator_tb.sv */
// Bench for the square-wave generator: registers, pin modes, wave timing
`timescale 1ns/1ps
`default_nettype none
module square_wave_frequency_generator_tb;
  localparam logic [15:0] A_RL = sqwg_pkg::IDX_RELOAD << sqwg_pkg::BYTE_SHIFT;
  localparam logic [15:0] A_CT = sqwg_pkg::IDX_COUNT << sqwg_pkg::BYTE_SHIFT;
  localparam logic [15:0] A_PC = sqwg_pkg::IDX_PINCTL << sqwg_pkg::BYTE_SHIFT;
  localparam logic [15:0] A_PS = sqwg_pkg::IDX_PINSTAT << sqwg_pkg::BYTE_SHIFT;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, po, poe;
  logic [15:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rd, q;
  wire logic pin = poe ? po : 1'b1; // Pull-up when released
  int errors = 0, n_tests = 0, rl = 255, half;
  int m_rl = sqwg_pkg::RST_RELOAD; // Bench model of the reload register
  sqwg_top #(.ADR_W(16), .STATE_DIV(1)) u_dut (.MCLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .SQW_PIN_I(pin), .SQW_PIN_O(po), .SQW_PIN_OE(poe));
  sqwg_load u_load (.MCLK(clk), .PIN(pin), .half(half));
  initial forever #4 clk = ~clk;
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle; one idle cycle between requests comes from the first wait
  task wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; wd <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 40) begin
      errors++;
      print_verdict;
    end
    q = rd;
    if (w && a == A_RL && s[0]) m_rl = d[7:0];
    cyc <= 0; stb <= 0;
  endtask
  initial begin
    void'($urandom(63035));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    wb(0, A_RL, 4'hF, 0); check(q, {24'h0, sqwg_pkg::RST_RELOAD});
    wb(0, 16'h0040, 4'hF, 0); check(q, 0);
    $display("reset test done");
    rl = $urandom % 8;
    wb(1, A_RL, 4'hF, rl); wb(0, A_RL, 4'hF, 0); check(q, m_rl);
    wb(1, A_RL, 4'hE, 8'hAA); wb(0, A_RL, 4'hF, 0); check(q, m_rl);
    $display("register test done");
    wb(1, A_PC, 4'hF, 3'b110); repeat (4) @(posedge clk); check({poe, po}, 2'b11);
    wb(1, A_PC, 4'hF, 3'b010); repeat (4) @(posedge clk); check(pin, 0);
    wb(0, A_PS, 4'hF, 0); check(q[0], 0);
    wb(1, A_PC, 4'hF, 3'b000); repeat (4) @(posedge clk); check(poe, 0);
    wb(0, A_PS, 4'hF, 0); check(q[0], 1);
    $display("pin test done");
    wb(1, A_PC, 4'hF, 3'b011);
    // The first expiry after reset already loads the written reload, so it governs the wave from the first expiry on, well inside the 2600-cycle wait
    repeat (2600) @(posedge clk);
    check(half, (m_rl + 1) * 8);
    wb(1, A_CT, 4'hF, 8'hF0); wb(0, A_CT, 4'hF, 0); check(q[31:8], 0);
    check(q[7:0] <= m_rl, 1);
    rl = 8 + $urandom % 8;
    wb(1, A_RL, 4'hF, rl);
    repeat (600) @(posedge clk);
    check(half, (m_rl + 1) * 8);
    $display("wave test done");
    print_verdict;
  end
endmodule
`default_nettype wire
